//--- core/reft_cfg.svh
// constants for the earth-fault trip decision block
// assumes: included by its bare name from core/ files only
`ifndef REFT_CFG_SVH
`define REFT_CFG_SVH

// ****************************************************
// widths
// ****************************************************
`define REFT_RAW_W 16
`define REFT_SET_W 10
`define REFT_VAL_W 22

// ****************************************************
// percent scale and sensitivity raise
// ****************************************************
`define REFT_PCT 100
`define REFT_RAISE 4

// ****************************************************
// setting ranges and reset defaults
// ****************************************************
`define REFT_PRI_MIN 10'h014
`define REFT_PRI_MAX 10'h1F4
`define REFT_PRI_DEF 10'h064
`define REFT_NEU_MIN 10'h064
`define REFT_NEU_MAX 10'h3E8
`define REFT_NEU_DEF 10'h1F4
`define REFT_BASE_MIN 10'h00A
`define REFT_BASE_MAX 10'h032
`define REFT_BASE_DEF 10'h01E
`define REFT_SLOPE_MIN 10'h032
`define REFT_SLOPE_MAX 10'h064
`define REFT_SLOPE_DEF 10'h046
`define REFT_BRK_MIN 10'h064
`define REFT_BRK_MAX 10'h0C8
`define REFT_BRK_DEF 10'h07D
`define REFT_DIRCHK_DEF 1'h1

`endif

//--- core/reft_pkg.sv
// types for the earth-fault trip decision block
// assumes: compiled before core/reft_decision.sv
`include "reft_cfg.svh"

package reft_pkg;

  // ****************************************************
  // operation setting
  // ****************************************************
  typedef enum logic [0:0] {
    REFT_OPER_OFF = 1'h0,
    REFT_OPER_ON = 1'h1
  } reft_oper_t;

  // one setting word
  typedef logic [`REFT_SET_W-1:0] reft_set_t;

  // one measured magnitude in percent
  typedef logic [`REFT_VAL_W-1:0] reft_val_t;

endpackage

//--- core/reft_decision.sv
// restricted earth-fault trip decision with its characteristic
// assumes: inputs synchronous to clock; current samples are
// fundamental magnitudes and vector components from upstream
`timescale 1ns/10ps
`include "reft_cfg.svh"

// Notes on behaviour
// - trip needs above-curve, unblocked, and enabled
// - blocked by enabled direction flag or user
// - operation Off/On, default On, Off kills trip
// - direction check enable, default true
// - sensitivity raise input multiplies base by four
// - user block input disables any trip
// - primary and neutral compensation ranges kept
// - slope 50 to 100, default 70
// - breakpoint 100 to 200, default 125
// - direction flag also driven as output
// - differential and bias currents published in percent
// - no delay timers in the decision
// - one general trip output
// - characteristic trip feeds the decision
// - bias is max of phase and neutral
// - direction flag set beyond plus/minus 90 degrees
module reft_decision (
  input wire logic clock,
  input wire logic reset_n,
  // phase and neutral magnitudes, raw percent of rated
  input wire logic [`REFT_RAW_W-1:0] phase1_mag,
  input wire logic [`REFT_RAW_W-1:0] phase2_mag,
  input wire logic [`REFT_RAW_W-1:0] phase3_mag,
  input wire logic [`REFT_RAW_W-1:0] neutral_mag,
  // zero-sequence and neutral vectors, signed components
  input wire logic signed [`REFT_RAW_W-1:0] zero_seq_re,
  input wire logic signed [`REFT_RAW_W-1:0] zero_seq_im,
  input wire logic signed [`REFT_RAW_W-1:0] neutral_re,
  input wire logic signed [`REFT_RAW_W-1:0] neutral_im,
  // user equation inputs
  input wire logic user_block_in,
  input wire logic sensitivity_raise_in,
  // settings, taken when settings_load is high
  input wire logic settings_load,
  input wire reft_pkg::reft_oper_t operation_setting,
  input wire logic direction_check_enable,
  input wire reft_pkg::reft_set_t primary_comp_setting,
  input wire reft_pkg::reft_set_t neutral_comp_setting,
  input wire reft_pkg::reft_set_t base_sensitivity_setting,
  input wire reft_pkg::reft_set_t slope_setting,
  input wire reft_pkg::reft_set_t breakpoint_setting,
  // results
  output reft_pkg::reft_val_t diff_current_value,
  output reft_pkg::reft_val_t bias_current_value,
  output logic char_internal_trip,
  output logic direction_block_flag,
  output logic final_trip_out
);

  // ****************************************************
  // helper functions
  // ****************************************************

  // clamp a setting into its documented range
  function automatic reft_pkg::reft_set_t clamp_set(
    input reft_pkg::reft_set_t v,
    input reft_pkg::reft_set_t lo,
    input reft_pkg::reft_set_t hi);
    if (v < lo) begin
      clamp_set = lo;
    end else if (v > hi) begin
      clamp_set = hi;
    end else begin
      clamp_set = v;
    end
  endfunction

  // scale an unsigned magnitude by a percent setting
  function automatic reft_pkg::reft_val_t comp_mag(
    input logic [`REFT_RAW_W-1:0] raw,
    input reft_pkg::reft_set_t pct);
    logic [25:0] prod;
    prod = raw * pct;
    comp_mag = `REFT_VAL_W'(prod / 26'(`REFT_PCT));
  endfunction

  // scale a signed component by a percent setting
  function automatic logic signed [20:0] comp_cmp(
    input logic signed [`REFT_RAW_W-1:0] raw,
    input reft_pkg::reft_set_t pct);
    logic signed [26:0] prod;
    prod = raw * $signed({1'b0, pct});
    comp_cmp = 21'(prod / 27'sd100);
  endfunction

  // absolute value of a summed component
  function automatic reft_pkg::reft_val_t abs_val(
    input logic signed [21:0] v);
    if (v[21]) begin
      abs_val = `REFT_VAL_W'(-v);
    end else begin
      abs_val = `REFT_VAL_W'(v);
    end
  endfunction

  // ****************************************************
  // settings registers
  // ****************************************************
  reft_pkg::reft_oper_t oper_q, oper_d; // operation mode
  logic dir_chk_q, dir_chk_d; // direction check enable
  reft_pkg::reft_set_t pri_q, pri_d; // primary compensation
  reft_pkg::reft_set_t neu_q, neu_d; // neutral compensation
  reft_pkg::reft_set_t base_q, base_d; // base sensitivity
  reft_pkg::reft_set_t slope_q, slope_d; // second slope
  reft_pkg::reft_set_t brk_q, brk_d; // breakpoint bias

  // load new settings, clamped, else hold
  always_comb begin
    oper_d = oper_q;
    dir_chk_d = dir_chk_q;
    pri_d = pri_q;
    neu_d = neu_q;
    base_d = base_q;
    slope_d = slope_q;
    brk_d = brk_q;
    if (settings_load) begin
      oper_d = operation_setting;
      dir_chk_d = direction_check_enable;
      pri_d = clamp_set(primary_comp_setting, `REFT_PRI_MIN,
        `REFT_PRI_MAX);
      neu_d = clamp_set(neutral_comp_setting, `REFT_NEU_MIN,
        `REFT_NEU_MAX);
      base_d = clamp_set(base_sensitivity_setting,
        `REFT_BASE_MIN, `REFT_BASE_MAX);
      slope_d = clamp_set(slope_setting, `REFT_SLOPE_MIN,
        `REFT_SLOPE_MAX);
      brk_d = clamp_set(breakpoint_setting, `REFT_BRK_MIN,
        `REFT_BRK_MAX);
    end
  end

  // settings flops, documented defaults at reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      oper_q <= reft_pkg::REFT_OPER_ON;
      dir_chk_q <= `REFT_DIRCHK_DEF;
      pri_q <= `REFT_PRI_DEF;
      neu_q <= `REFT_NEU_DEF;
      base_q <= `REFT_BASE_DEF;
      slope_q <= `REFT_SLOPE_DEF;
      brk_q <= `REFT_BRK_DEF;
    end else begin
      oper_q <= oper_d;
      dir_chk_q <= dir_chk_d;
      pri_q <= pri_d;
      neu_q <= neu_d;
      base_q <= base_d;
      slope_q <= slope_d;
      brk_q <= brk_d;
    end
  end

  // ****************************************************
  // stage one: compensation and direction
  // ****************************************************
  logic [`REFT_RAW_W-1:0] phase_raw [3]; // phase inputs as array
  reft_pkg::reft_val_t ph_q [3]; // compensated phases
  reft_pkg::reft_val_t ph_d [3];
  reft_pkg::reft_val_t nmag_q, nmag_d; // compensated neutral
  reft_pkg::reft_val_t dmag_q, dmag_d; // residual vector size
  logic dir_q, dir_d; // angle beyond right angle
  logic raise1_q, raise1_d; // raise input, aligned
  logic signed [21:0] sum_re; // residual real part
  logic signed [21:0] sum_im; // residual imaginary part
  reft_pkg::reft_val_t abs_re; // magnitude of real part
  reft_pkg::reft_val_t abs_im; // magnitude of imaginary part
  logic signed [32:0] dot; // dot product of the two vectors

  assign phase_raw[0] = phase1_mag;
  assign phase_raw[1] = phase2_mag;
  assign phase_raw[2] = phase3_mag;

  // one compensator per phase
  for (genvar i = 0; i < 3; i++) begin : g_phase
    assign ph_d[i] = comp_mag(phase_raw[i], pri_q);
  end

  // neutral compensation, residual size, direction
  always_comb begin
    nmag_d = comp_mag(neutral_mag, neu_q);
    sum_re = 22'(comp_cmp(zero_seq_re, pri_q))
      + 22'(comp_cmp(neutral_re, neu_q));
    sum_im = 22'(comp_cmp(zero_seq_im, pri_q))
      + 22'(comp_cmp(neutral_im, neu_q));
    abs_re = abs_val(sum_re);
    abs_im = abs_val(sum_im);
    // larger part plus half the smaller, no root needed
    if (abs_re > abs_im) begin
      dmag_d = abs_re + (abs_im >> 1);
    end else begin
      dmag_d = abs_im + (abs_re >> 1);
    end
    // negative dot product means outside plus/minus 90
    dot = 33'(zero_seq_re * neutral_re)
      + 33'(zero_seq_im * neutral_im);
    dir_d = dot[32];
    raise1_d = sensitivity_raise_in;
  end

  // stage one flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < 3; k++) begin
        ph_q[k] <= '0;
      end
      nmag_q <= '0;
      dmag_q <= '0;
      dir_q <= 1'h0;
      raise1_q <= 1'h0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        ph_q[k] <= ph_d[k];
      end
      nmag_q <= nmag_d;
      dmag_q <= dmag_d;
      dir_q <= dir_d;
      raise1_q <= raise1_d;
    end
  end

  // ****************************************************
  // stage two: bias and published values
  // ****************************************************
  reft_pkg::reft_val_t diff_q, diff_d; // differential current
  reft_pkg::reft_val_t bias_q, bias_d; // restraint current
  logic dir2_q, dir2_d; // direction flag, aligned
  logic raise2_q, raise2_d; // raise input, aligned

  // bias is the largest of the four magnitudes
  always_comb begin
    bias_d = nmag_q;
    for (int k = 0; k < 3; k++) begin
      if (ph_q[k] > bias_d) begin
        bias_d = ph_q[k];
      end
    end
    diff_d = dmag_q;
    dir2_d = dir_q;
    raise2_d = raise1_q;
  end

  // stage two flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      diff_q <= '0;
      bias_q <= '0;
      dir2_q <= 1'h0;
      raise2_q <= 1'h0;
    end else begin
      diff_q <= diff_d;
      bias_q <= bias_d;
      dir2_q <= dir2_d;
      raise2_q <= raise2_d;
    end
  end

  assign diff_current_value = diff_q;
  assign bias_current_value = bias_q;

  // ****************************************************
  // stage three: characteristic
  // ****************************************************
  logic ctrip_q, ctrip_d; // above the characteristic
  logic dir3_q, dir3_d; // direction flag, aligned
  logic [11:0] base_eff; // base after optional raise
  logic [31:0] lhs; // differential, scaled by 100
  logic [31:0] rhs; // threshold, scaled by 100

  // both sides scaled by 100 so no divider is needed
  always_comb begin
    if (raise2_q) begin
      base_eff = 12'(base_q * `REFT_RAISE);
    end else begin
      base_eff = 12'(base_q);
    end
    lhs = 32'(diff_q * `REFT_PCT);
    rhs = 32'(base_eff * `REFT_PCT);
    if (bias_q > `REFT_VAL_W'(brk_q)) begin
      // line rising from the breakpoint at the slope
      rhs = rhs + 32'(slope_q * (bias_q
        - `REFT_VAL_W'(brk_q)));
    end
    ctrip_d = lhs > rhs;
    dir3_d = dir2_q;
  end

  // stage three flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrip_q <= 1'h0;
      dir3_q <= 1'h0;
    end else begin
      ctrip_q <= ctrip_d;
      dir3_q <= dir3_d;
    end
  end

  assign char_internal_trip = ctrip_q;
  assign direction_block_flag = dir3_q;

  // ****************************************************
  // stage four: decision logic, no timers
  // ****************************************************
  logic trip_q, trip_d; // general trip
  logic blocked; // function blocked this cycle

  // combine conditions directly, every cycle
  always_comb begin
    blocked = (dir_chk_q & dir3_q)
      | user_block_in;
    trip_d = ctrip_q
      & ~blocked
      & (oper_q == reft_pkg::REFT_OPER_ON);
  end

  // trip flop, cleared by reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      trip_q <= 1'h0;
    end else begin
      trip_q <= trip_d;
    end
  end

  assign final_trip_out = trip_q;

endmodule

//--- verification/reft_decision_properties.sv
// checker of the trip decision ports
// assumes: bound onto reft_decision, settings taken on settings_load
`timescale 1ns/10ps
module reft_decision_properties (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic signed [15:0] zero_seq_re,
  input wire logic signed [15:0] zero_seq_im,
  input wire logic signed [15:0] neutral_re,
  input wire logic signed [15:0] neutral_im,
  input wire logic user_block_in,
  input wire logic settings_load,
  input wire reft_pkg::reft_oper_t operation_setting,
  input wire logic direction_check_enable,
  input wire reft_pkg::reft_val_t diff_current_value,
  input wire reft_pkg::reft_val_t bias_current_value,
  input wire logic char_internal_trip,
  input wire logic direction_block_flag,
  input wire logic final_trip_out
);
  // ****
  // held copies of the gating settings and of the raw vector sign
  // ****
  logic on_q, on_d; // operation on
  logic dc_q, dc_d; // direction check on
  logic neg_q, neg_d; // raw vectors opposed
  // next values, settings only move on a load
  always_comb begin
    on_d = on_q;
    dc_d = dc_q;
    if (settings_load) begin
      on_d = operation_setting == reft_pkg::REFT_OPER_ON;
      dc_d = direction_check_enable;
    end
    // wide enough that two products never overflow
    neg_d = zero_seq_re * neutral_re + zero_seq_im * neutral_im < 34'sh0;
  end
  // register with the defaults of reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      on_q <= 1'h1;
      dc_q <= 1'h1;
      neg_q <= 1'h0;
    end else begin
      on_q <= on_d;
      dc_q <= dc_d;
      neg_q <= neg_d;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_dir_block;
    dc_q && direction_block_flag;
  endsequence
  sequence s_free_pass;
    char_internal_trip && on_q && !user_block_in && !dc_q;
  endsequence
  AST_TRIP_COMBINE: assert property (
    final_trip_out == $past(char_internal_trip && on_q
      && !(user_block_in || (dc_q && direction_block_flag))))
    else $error("trip differs from its combined conditions");
  AST_OFF_SILENT: assert property (!on_q |=> !final_trip_out)
    else $error("trip while operation off");
  AST_USER_SILENT: assert property (
    user_block_in |=> !final_trip_out)
    else $error("trip while user block set");
  AST_DIR_BLOCKS: assert property (s_dir_block |=> !final_trip_out)
    else $error("trip through direction block");
  AST_DIR_IGNORED: assert property (s_free_pass |=> final_trip_out)
    else $error("direction flag blocks while check off");
  AST_DIR_FLAG: assert property (
    direction_block_flag == $past(neg_q, 2))
    else $error("direction flag wrong for vector angle");
  AST_CHAR_FLOOR: assert property (
    char_internal_trip |-> $past(diff_current_value) > 22'h00000A)
    else $error("char trip below lowest base");
  AST_CHAR_SURE: assert property (
    $past(diff_current_value) > 22'h0000C8
      && $past(bias_current_value) <= 22'h000064 |-> char_internal_trip)
    else $error("no char trip above highest flat level");
  AST_RESET_QUIET: assert property (
    $rose(reset_n) |-> !final_trip_out && !char_internal_trip)
    else $error("outputs not clear after reset");
endmodule
bind reft_decision reft_decision_properties chk_u (.clock(clock),
  .reset_n(reset_n), .zero_seq_re(zero_seq_re), .zero_seq_im(zero_seq_im),
  .neutral_re(neutral_re), .neutral_im(neutral_im),
  .user_block_in(user_block_in), .settings_load(settings_load),
  .operation_setting(operation_setting),
  .direction_check_enable(direction_check_enable),
  .diff_current_value(diff_current_value),
  .bias_current_value(bias_current_value),
  .char_internal_trip(char_internal_trip),
  .direction_block_flag(direction_block_flag),
  .final_trip_out(final_trip_out));

//--- verification/reft_user_model.sv
// model of the user equations and the setting software
// assumes: driven by task calls from the bench top
`timescale 1ns/10ps
module reft_user_model (
  input wire logic clock,
  output logic settings_load,
  output reft_pkg::reft_oper_t operation_setting,
  output logic direction_check_enable,
  output reft_pkg::reft_set_t primary_comp_setting,
  output reft_pkg::reft_set_t neutral_comp_setting,
  output reft_pkg::reft_set_t base_sensitivity_setting,
  output reft_pkg::reft_set_t slope_setting,
  output reft_pkg::reft_set_t breakpoint_setting,
  output logic user_block_in,
  output logic sensitivity_raise_in
);
  // nothing loaded until asked
  initial begin
    settings_load = 1'h0;
    user_block_in = 1'h0;
    sensitivity_raise_in = 1'h0;
  end
  // one load pulse carrying all seven settings
  task automatic load(input logic op, dc, input reft_pkg::reft_set_t pri,
    neu, base, slope, brk);
    @(posedge clock);
    #1;
    operation_setting = reft_pkg::reft_oper_t'(op);
    direction_check_enable = dc;
    {primary_comp_setting, neutral_comp_setting, base_sensitivity_setting,
      slope_setting, breakpoint_setting} = {pri, neu, base, slope, brk};
    settings_load = 1'h1;
    @(posedge clock);
    #1;
    settings_load = 1'h0;
    // once taken, the values are not held for the block
    operation_setting = reft_pkg::reft_oper_t'(~op);
    direction_check_enable = ~dc;
    {primary_comp_setting, neutral_comp_setting, base_sensitivity_setting,
      slope_setting, breakpoint_setting} = ~{pri, neu, base, slope, brk};
  endtask
  // user equation outputs
  task automatic user(input logic blk, rse);
    @(posedge clock);
    #1;
    user_block_in = blk;
    sensitivity_raise_in = rse;
  endtask
endmodule

//--- verification/reft_decision_tb_top.sv
// self-checking bench of the earth-fault trip decision
// assumes: package compiled first, user model beside the block
`timescale 1ns/10ps
module reft_decision_tb_top;
  logic clock, reset_n, settings_load, direction_check_enable;
  logic user_block_in, sensitivity_raise_in;
  logic [15:0] phase1_mag, phase2_mag, phase3_mag, neutral_mag;
  logic signed [15:0] zero_seq_re, zero_seq_im, neutral_re, neutral_im;
  reft_pkg::reft_oper_t operation_setting;
  reft_pkg::reft_set_t primary_comp_setting, neutral_comp_setting;
  reft_pkg::reft_set_t base_sensitivity_setting, slope_setting;
  reft_pkg::reft_set_t breakpoint_setting;
  reft_pkg::reft_val_t diff_current_value, bias_current_value;
  logic char_internal_trip, direction_block_flag, final_trip_out;
  int n_fail, cmp_count, cyc;
  int s_on, s_dc, s_pri, s_neu, s_base, s_slope, s_brk, s_blk, s_rs;
  reft_decision dut_u (.clock, .reset_n, .phase1_mag, .phase2_mag,
    .phase3_mag, .neutral_mag, .zero_seq_re, .zero_seq_im, .neutral_re,
    .neutral_im, .user_block_in, .sensitivity_raise_in, .settings_load,
    .operation_setting, .direction_check_enable, .primary_comp_setting,
    .neutral_comp_setting, .base_sensitivity_setting, .slope_setting,
    .breakpoint_setting, .diff_current_value, .bias_current_value,
    .char_internal_trip, .direction_block_flag, .final_trip_out);
  reft_user_model pm_u (.clock, .settings_load, .operation_setting,
    .direction_check_enable, .primary_comp_setting, .neutral_comp_setting,
    .base_sensitivity_setting, .slope_setting, .breakpoint_setting,
    .user_block_in, .sensitivity_raise_in);
  // 200 MHz clock
  initial clock = 1'h0;
  always #2.5 clock = ~clock;
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      conclude;
    end
  end
  task automatic check(input string nm, input logic [21:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic int clamp(int v, int lo, int hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction
  // settings through the model, mirrors kept clamped
  task automatic set(int on, dc, pri, neu, base, slope, brk);
    {s_on, s_dc} = {on, dc};
    s_pri = clamp(pri, 20, 500);
    s_neu = clamp(neu, 100, 1000);
    s_base = clamp(base, 10, 50);
    s_slope = clamp(slope, 50, 100);
    s_brk = clamp(brk, 100, 200);
    pm_u.load(1'(on), 1'(dc), 10'(pri), 10'(neu), 10'(base), 10'(slope),
      10'(brk));
  endtask
  task automatic usr(int blk, rs);
    {s_blk, s_rs} = {blk, rs};
    pm_u.user(1'(blk), 1'(rs));
  endtask
  // apply one current picture, let it settle, check every output
  task automatic run(string nm, int p, n, zr, zi, nr, ni);
    int re, im, a, b, d, bs, thr, ch, dr;
    @(posedge clock);
    #1;
    {phase1_mag, phase2_mag, phase3_mag} = {16'(p / 2), 16'(p), 16'(p / 3)};
    {neutral_mag, zero_seq_re, zero_seq_im} = {16'(n), 16'(zr), 16'(zi)};
    {neutral_re, neutral_im} = {16'(nr), 16'(ni)};
    repeat (5) @(posedge clock);
    #1;
    re = zr * s_pri / 100 + nr * s_neu / 100;
    im = zi * s_pri / 100 + ni * s_neu / 100;
    a = re < 0 ? -re : re;
    b = im < 0 ? -im : im;
    d = a > b ? a + b / 2 : b + a / 2;
    bs = p * s_pri / 100 > n * s_neu / 100 ? p * s_pri / 100 : n * s_neu / 100;
    thr = (s_rs ? 4 : 1) * s_base * 100;
    if (bs > s_brk) thr += s_slope * (bs - s_brk);
    ch = d * 100 > thr;
    dr = zr * nr + zi * ni < 0;
    check("diff", diff_current_value, 22'(d));
    check("bias", bias_current_value, 22'(bs));
    check("char", 22'(char_internal_trip), 22'(ch));
    check("dir", 22'(direction_block_flag), 22'(dr));
    check("trip", 22'(final_trip_out),
      22'(ch && s_on && !(s_blk || (s_dc && dr))));
    $display("test %s done", nm);
  endtask
  initial begin
    {reset_n, phase1_mag, phase2_mag, phase3_mag, neutral_mag} = '0;
    {zero_seq_re, zero_seq_im, neutral_re, neutral_im} = '0;
    // reset at start, then once more in mid-run
    repeat (2) begin
      reset_n = 1'h0;
      s_on = 1;
      s_dc = 1;
      s_pri = 100;
      s_neu = 500;
      s_base = 30;
      s_slope = 70;
      s_brk = 125;
      s_blk = 0;
      s_rs = 0;
      repeat (2) @(posedge clock);
      #1;
      check("rst", 22'(final_trip_out), 22'h0);
      check("rst_char", 22'(char_internal_trip), 22'h0);
      reset_n = 1'h1;
      run("inside", 50, 10, 20, 0, 10, 0);
    end
    run("vector", 40, 8, 30, 40, 0, -6);
    run("through", 50, 10, -100, 0, 10, 0);
    usr(0, 1);
    run("raise", 50, 10, 20, 0, 10, 0);
    run("big", 40, 20, 0, 0, 50, 0);
    usr(1, 0);
    run("user", 50, 10, 20, 0, 10, 0);
    usr(0, 0);
    run("slope_hi", 300, 10, 100, 0, 11, 0);
    run("slope_lo", 300, 10, 100, 0, 10, 0);
    run("brk_eq", 125, 10, 1, 0, 6, 0);
    set(0, 1, 100, 500, 30, 70, 125);
    run("off", 50, 10, 20, 0, 10, 0);
    set(1, 0, 100, 500, 30, 70, 125);
    run("dir_off", 50, 10, -100, 0, 10, 0);
    set(1, 1, 20, 1000, 10, 50, 200);
    run("min", 1000, 10, 5, 0, 1, 0);
    run("slope_min", 1100, 10, 5, 0, 1, 0);
    set(1, 1, 19, 1001, 60, 200, 300);
    run("clamp", 1100, 10, 5, 0, 7, 0);
    conclude;
  end
endmodule
